// *** pkg/phw_pkg.sv ***
// Purpose: shared constants and types of the PCM highway slot block
// Assumes: 8-bit register port, 10-bit slot start counts
// Notes: codec constants follow the usual companding curves
package phw_pkg;
   // register offsets
   localparam logic [7:0] PHW_A_MODE = 8'h21;
   localparam logic [7:0] PHW_A_TXLO = 8'h22;
   localparam logic [7:0] PHW_A_TXHI = 8'h23;
   localparam logic [7:0] PHW_A_RXLO = 8'h24;
   localparam logic [7:0] PHW_A_RXHI = 8'h25;
   // field positions in the mode register
   localparam int PHW_B_LOOP = 7;
   localparam int PHW_B_EN = 5;
   localparam int PHW_B_FMT = 3;
   localparam int PHW_B_CPB = 1;
   localparam int PHW_B_TRI = 0;
   // values after reset
   localparam logic [7:0] PHW_RST_MODE = 8'h00;
   localparam logic [7:0] PHW_RST_SLOT = 8'h00;
   localparam logic [10:0] PHW_CNT_IDLE = 11'h7FF;
   // bit counts of a slot, width of the settled settings
   localparam logic [4:0] PHW_BITS_NARROW = 5'h08;
   localparam logic [4:0] PHW_BITS_WIDE = 5'h10;
   localparam int PHW_CFG_W = 25;
   // companding constants
   localparam logic [13:0] PHW_MU_CLIP = 14'h1FDE;
   localparam logic [13:0] PHW_MU_EBIAS = 14'h0021;
   localparam logic [15:0] PHW_MU_DBIAS = 16'h0084;
   localparam logic [15:0] PHW_A_DBIAS = 16'h0108;
   localparam logic [15:0] PHW_A_SEG0 = 16'h0008;
   localparam logic [7:0] PHW_A_XOR_N = 8'h55;
   localparam logic [7:0] PHW_A_XOR_P = 8'hD5;
   localparam logic [7:0] PHW_MU_MASK_N = 8'h7F;
   localparam logic [7:0] PHW_MU_MASK_P = 8'hFF;
   typedef enum logic [1:0] {
      PHW_FMT_ALAW = 2'b00,
      PHW_FMT_MULAW = 2'b01,
      PHW_FMT_LIN8 = 2'b10,
      PHW_FMT_LIN16 = 2'b11
   } phw_fmt_e;
   typedef enum logic {PHW_IDLE = 1'b0, PHW_SHIFT = 1'b1} phw_slot_e;
endpackage

// *** rtl/phw_sync.sv ***
// Purpose: two-flop level synchroniser
// Assumes: input is stable long enough to be seen
// Notes: clr_b is synchronous to clk
module phw_sync #(parameter int W = 1) (
   input wire logic clk,  // destination clock
   input wire logic clr_b,  // synchronous clear, low
   input wire logic [W-1:0] d,  // foreign level
   output logic [W-1:0] q  // settled level
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } phw_sync_s;
   phw_sync_s st;
   phw_sync_s next_st;
   // first stage only feeds the second
   always_comb begin
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end
   always_ff @(posedge clk) begin
      if (!clr_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign q = st.s2;
endmodule // phw_sync

// *** rtl/phw_highway.sv ***
// Purpose: PCM highway mode registers, slot timing and sample coding
// Assumes: pclk and frame_sync come from the host; registers on mclk
// Notes: slot counts should be settled before transfers are enabled

module phw_highway import phw_pkg::*; (
   input wire logic mclk,  // register clock
   input wire logic rst_b,  // sync reset, low
   input wire logic [7:0] reg_addr,  // register offset
   input wire logic [7:0] reg_wdata,  // write data
   input wire logic reg_wr,  // write strobe
   input wire logic reg_rd,  // read strobe
   output logic [7:0] reg_rdata,  // read data
   input wire logic pclk,  // highway clock
   input wire logic frame_sync,  // frame start
   input wire logic pcm_din,  // serial in
   output logic pcm_dout,  // serial out
   output logic pcm_dout_oe,  // serial out drive
   input wire logic [15:0] adc_sample,  // line sample
   input wire logic adc_valid,  // line sample strobe
   output logic [15:0] dac_sample,  // sample to line
   output logic dac_valid  // line sample strobe
);
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] txs_lo;
      logic [1:0] txs_hi;
      logic [7:0] rxs_lo;
      logic [1:0] rxs_hi;
      logic [7:0] rdata;
      logic [15:0] adc_word;
      logic adc_pend;
      logic [15:0] tx_hold;
      logic tx_req;
      logic rx_s3;
      logic [15:0] dac_sample;
      logic dac_valid;
   } phw_reg_s;

   typedef struct packed {
      logic fs_d;
      logic [10:0] cnt;
      logic [15:0] tx_next;
      logic tx_ack;
      phw_slot_e tx_st;
      logic [15:0] tx_sh;
      logic [4:0] tx_left;
      logic tx_ph;
      logic dout;
      logic oe;
      phw_slot_e rx_st;
      logic [15:0] rx_sh;
      logic [4:0] rx_left;
      logic rx_ph;
      logic [15:0] rx_word;
      logic rx_tgl;
   } phw_lnk_s;

   typedef struct packed {
      logic din_n;
      logic oe_n;
   } phw_neg_s;

   phw_reg_s r;
   phw_reg_s next_r;
   phw_lnk_s l;
   phw_lnk_s next_l;
   phw_neg_s n;
   logic lrst_b;
   logic ack_s;
   logic rx_s2;
   logic req_s;
   logic [PHW_CFG_W-1:0] cfg_s;
   logic launch;
   logic rx_ev;
   logic loop;
   phw_fmt_e fmt;
   logic c_en;
   logic c_cpb;
   logic c_tri;
   logic c_wide;
   logic [9:0] c_txs;
   logic [9:0] c_rxs;
   logic [4:0] nbits;
   logic [15:0] ld;

   // A-law coding of a linear sample
   function automatic logic [7:0] a_enc(input logic [15:0] s);
      logic [11:0] m;
      logic [2:0] seg;
      logic [3:0] man;
      m = s[15] ? ~s[14:3] : s[14:3];
      seg = 3'h0;
      for (int i = 5; i < 12; i++) begin
         if (m[i]) begin
            seg = 3'(i - 4);
         end
      end
      man = (seg == 3'h0) ? m[4:1] : 4'(m >> seg);
      return {1'b0, seg, man} ^ (s[15] ? PHW_A_XOR_N : PHW_A_XOR_P);
   endfunction

   // mu-law coding of a linear sample
   function automatic logic [7:0] mu_enc(input logic [15:0] s);
      logic [15:0] a;
      logic [13:0] m;
      logic [2:0] seg;
      logic [3:0] man;
      a = s[15] ? (~s) + 16'h0001 : s;
      m = a[15:2];
      if (m > PHW_MU_CLIP) begin
         m = PHW_MU_CLIP;
      end
      m = m + PHW_MU_EBIAS;
      seg = 3'h0;
      for (int i = 5; i < 13; i++) begin
         if (m[i]) begin
            seg = 3'(i - 5);
         end
      end
      man = 4'(m >> ({1'b0, seg} + 4'h1));
      return {1'b0, seg, man} ^ (s[15] ? PHW_MU_MASK_N : PHW_MU_MASK_P);
   endfunction

   // A-law word back to linear
   function automatic logic [15:0] a_dec(input logic [7:0] c);
      logic [7:0] a;
      logic [15:0] t;
      a = c ^ PHW_A_XOR_N;
      t = {8'h00, a[3:0], 4'h0};
      if (a[6:4] == 3'h0) begin
         t = t + PHW_A_SEG0;
      end else begin
         t = (t + PHW_A_DBIAS) << (a[6:4] - 3'h1);
      end
      return a[7] ? t : (~t) + 16'h0001;
   endfunction

   // mu-law word back to linear
   function automatic logic [15:0] mu_dec(input logic [7:0] c);
      logic [7:0] u;
      logic [15:0] t;
      u = ~c;
      t = ({9'h000, u[3:0], 3'h0} + PHW_MU_DBIAS) << u[6:4];
      return u[7] ? PHW_MU_DBIAS - t : t - PHW_MU_DBIAS;
   endfunction

   // full linear word passes as is
   // line sample to highway word, 8-bit codes in the low byte
   function automatic logic [15:0] tx_form(input phw_fmt_e f, input logic [15:0] w);
      logic [15:0] o;
      unique case (f)
         PHW_FMT_ALAW: o = {8'h00, a_enc(w)};
         PHW_FMT_MULAW: o = {8'h00, mu_enc(w)};
         PHW_FMT_LIN8: o = {8'h00, w[15:8]};
         PHW_FMT_LIN16: o = w;
      endcase
      return o;
   endfunction

   // highway word to line sample
   function automatic logic [15:0] rx_form(input phw_fmt_e f, input logic [15:0] w);
      logic [15:0] o;
      unique case (f)
         PHW_FMT_ALAW: o = a_dec(w[7:0]);
         PHW_FMT_MULAW: o = mu_dec(w[7:0]);
         PHW_FMT_LIN8: o = {w[7:0], 8'h00};
         PHW_FMT_LIN16: o = w;
      endcase
      return o;
   endfunction

   // crossings between the two clocks
   phw_sync #(.W(1)) u_rst (.clk(pclk), .clr_b(1'b1), .d(rst_b), .q(lrst_b));
   phw_sync #(.W(1)) u_ack (.clk(mclk), .clr_b(rst_b), .d(l.tx_ack), .q(ack_s));
   phw_sync #(.W(1)) u_rxt (.clk(mclk), .clr_b(rst_b), .d(l.rx_tgl), .q(rx_s2));
   phw_sync #(.W(1)) u_req (.clk(pclk), .clr_b(lrst_b), .d(r.tx_req), .q(req_s));
   phw_sync #(.W(PHW_CFG_W)) u_cfg (
      .clk(pclk),
      .clr_b(lrst_b),
      .d({r.mode[PHW_B_EN], r.mode[PHW_B_FMT+:2], r.mode[PHW_B_CPB],
          r.mode[PHW_B_TRI], r.txs_hi, r.txs_lo, r.rxs_hi, r.rxs_lo}),
      .q(cfg_s)
   );

   // register side decode
   assign fmt = phw_fmt_e'(r.mode[PHW_B_FMT+:2]);
   assign loop = r.mode[PHW_B_LOOP];
   assign launch = r.adc_pend && (r.tx_req == ack_s);
   assign rx_ev = rx_s2 != r.rx_s3;

   // register file, sample hand-off and line return
   always_comb begin
      next_r = r;
      next_r.dac_valid = 1'b0;
      next_r.rx_s3 = rx_s2;
      if (reg_wr) begin
         case (reg_addr)
            PHW_A_MODE: next_r.mode = reg_wdata;
            PHW_A_TXLO: next_r.txs_lo = reg_wdata;
            PHW_A_TXHI: next_r.txs_hi = reg_wdata[1:0];
            PHW_A_RXLO: next_r.rxs_lo = reg_wdata;
            PHW_A_RXHI: next_r.rxs_hi = reg_wdata[1:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            PHW_A_MODE: next_r.rdata = r.mode;
            PHW_A_TXLO: next_r.rdata = r.txs_lo;
            PHW_A_TXHI: next_r.rdata = {6'h00, r.txs_hi};
            PHW_A_RXLO: next_r.rdata = r.rxs_lo;
            PHW_A_RXHI: next_r.rdata = {6'h00, r.rxs_hi};
            default: next_r.rdata = 8'h00;
         endcase
      end
      if (launch) begin
         next_r.tx_hold = tx_form(fmt, r.adc_word);
         next_r.tx_req = ~r.tx_req;
         next_r.adc_pend = 1'b0;
      end
      // a new sample wins over the launch clear
      if (adc_valid) begin
         next_r.adc_word = adc_sample;
         next_r.adc_pend = 1'b1;
      end
      if (rx_ev && !loop) begin
         next_r.dac_sample = rx_form(fmt, l.rx_word);
         next_r.dac_valid = 1'b1;
      end
      if (loop && adc_valid) begin
         next_r.dac_sample = adc_sample;
         next_r.dac_valid = 1'b1;
      end
   end

   // register side state
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         r <= '0;
         r.mode <= PHW_RST_MODE;
         r.txs_lo <= PHW_RST_SLOT;
         r.rxs_lo <= PHW_RST_SLOT;
      end else begin
         r <= next_r;
      end
   end

   // settled highway settings
   assign c_en = cfg_s[24];
   assign c_wide = cfg_s[23:22] == PHW_FMT_LIN16;
   assign c_cpb = cfg_s[21];
   assign c_tri = cfg_s[20];
   assign c_txs = cfg_s[19:10];
   assign c_rxs = cfg_s[9:0];
   assign nbits = c_wide ? PHW_BITS_WIDE : PHW_BITS_NARROW;
   // narrow words sit in the top byte
   assign ld = c_wide ? l.tx_next : {l.tx_next[7:0], 8'h00};

   // highway slot engine
   always_comb begin
      next_l = l;
      next_l.fs_d = frame_sync;
      if (frame_sync && !l.fs_d) begin
         next_l.cnt = 11'h000;
      end else if (l.cnt != PHW_CNT_IDLE) begin
         next_l.cnt = l.cnt + 11'h001;
      end
      if (req_s != l.tx_ack) begin
         next_l.tx_next = r.tx_hold;
         next_l.tx_ack = req_s;
      end
      unique case (l.tx_st)
         PHW_IDLE: begin
            if (c_en && l.cnt == {1'b0, c_txs}) begin
               next_l.tx_st = PHW_SHIFT;
               next_l.dout = ld[15];
               next_l.tx_sh = {ld[14:0], 1'b0};
               next_l.tx_left = nbits - 5'h01;
               next_l.tx_ph = 1'b0;
               next_l.oe = 1'b1;
            end
         end
         PHW_SHIFT: begin
            if (c_cpb && !l.tx_ph) begin
               next_l.tx_ph = 1'b1;
            end else begin
               next_l.tx_ph = 1'b0;
               if (l.tx_left == 5'h00) begin
                  next_l.oe = 1'b0;
                  next_l.tx_st = PHW_IDLE;
               end else begin
                  next_l.dout = l.tx_sh[15];
                  next_l.tx_sh = {l.tx_sh[14:0], 1'b0};
                  next_l.tx_left = l.tx_left - 5'h01;
               end
            end
         end
      endcase
      unique case (l.rx_st)
         PHW_IDLE: begin
            if (c_en && l.cnt == {1'b0, c_rxs}) begin
               next_l.rx_st = PHW_SHIFT;
               next_l.rx_sh = 16'h0000;
               next_l.rx_left = nbits;
               next_l.rx_ph = 1'b0;
            end
         end
         PHW_SHIFT: begin
            if (c_cpb && !l.rx_ph) begin
               next_l.rx_ph = 1'b1;
            end else begin
               next_l.rx_ph = 1'b0;
               next_l.rx_sh = {l.rx_sh[14:0], n.din_n};
               next_l.rx_left = l.rx_left - 5'h01;
               if (l.rx_left == 5'h01) begin
                  next_l.rx_word = {l.rx_sh[14:0], n.din_n};
                  next_l.rx_tgl = ~l.rx_tgl;
                  next_l.rx_st = PHW_IDLE;
               end
            end
         end
      endcase
      if (!c_en) begin
         next_l.tx_st = PHW_IDLE;
         next_l.rx_st = PHW_IDLE;
         next_l.oe = 1'b0;
      end
   end

   // highway side state, rising edge
   always_ff @(posedge pclk) begin
      if (!lrst_b) begin
         l <= '0;
         l.cnt <= PHW_CNT_IDLE;
      end else begin
         l <= next_l;
      end
   end

   // falling edge: receive sample and late release
   always_ff @(negedge pclk) begin
      if (!lrst_b) begin
         n <= '0;
      end else begin
         n.din_n <= pcm_din;
         n.oe_n <= l.oe;
      end
   end

   // outputs
   assign reg_rdata = r.rdata;
   assign dac_sample = r.dac_sample;
   assign dac_valid = r.dac_valid;
   assign pcm_dout = l.dout;
   // late release holds until the next falling edge
   assign pcm_dout_oe = l.oe | (c_tri & n.oe_n);

   property p_loop;
      @(posedge mclk) disable iff (!rst_b)
      loop && adc_valid |=> r.dac_valid && r.dac_sample == $past(adc_sample);
   endproperty
   a_loop: assert property (p_loop) else $error("loopback sample lost");

   property p_lin8;
      @(posedge mclk) disable iff (!rst_b)
      launch && fmt == PHW_FMT_LIN8 |=> r.tx_hold == {8'h00, $past(r.adc_word[15:8])};
   endproperty
   a_lin8: assert property (p_lin8) else $error("8-bit linear word wrong");

   property p_alaw;
      @(posedge mclk) disable iff (!rst_b)
      launch && fmt == PHW_FMT_ALAW |=> r.tx_hold[7] == !$past(r.adc_word[15]);
   endproperty
   a_alaw: assert property (p_alaw) else $error("A-law sign wrong");

   property p_mulaw;
      @(posedge mclk) disable iff (!rst_b)
      launch && fmt == PHW_FMT_MULAW && r.adc_word == 16'h0000 |=> r.tx_hold == 16'h00FF;
   endproperty
   a_mulaw: assert property (p_mulaw) else $error("mu-law zero wrong");

   property p_lin16;
      @(posedge mclk) disable iff (!rst_b)
      rx_ev && !loop && fmt == PHW_FMT_LIN16 |=> r.dac_valid && r.dac_sample == $past(l.rx_word);
   endproperty
   a_lin16: assert property (p_lin16) else $error("16-bit receive wrong");

   property p_off;
      @(posedge pclk) disable iff (!lrst_b)
      !c_en |=> !l.oe && l.rx_st == PHW_IDLE;
   endproperty
   a_off: assert property (p_off) else $error("transfer while disabled");

   property p_txgo;
      @(posedge pclk) disable iff (!lrst_b)
      c_en && l.tx_st == PHW_IDLE && l.cnt == {1'b0, c_txs} |=> l.oe && l.dout == $past(ld[15]);
   endproperty
   a_txgo: assert property (p_txgo) else $error("transmit slot late");

   property p_hold;
      @(posedge pclk) disable iff (!lrst_b)
      c_en && l.tx_st == PHW_SHIFT && c_cpb && !l.tx_ph |=> $stable(l.dout) && l.oe;
   endproperty
   a_hold: assert property (p_hold) else $error("bit shorter than two pclks");

   // judged at the falling edge, where a late release still drives
   property p_rel;
      @(negedge pclk) disable iff (!lrst_b)
      $fell(l.oe) |-> pcm_dout_oe == c_tri;
   endproperty
   a_rel: assert property (p_rel) else $error("release edge wrong");

   property p_rxlen;
      @(posedge pclk) disable iff (!lrst_b)
      c_en && l.rx_st == PHW_IDLE && l.cnt == {1'b0, c_rxs} && !c_cpb && !c_wide
         ##1 c_en [*8] |=> $changed(l.rx_tgl);
   endproperty
   a_rxlen: assert property (p_rxlen) else $error("receive slot length wrong");
endmodule // phw_highway

// *** dv/phw_host.sv ***
// Purpose: behavioural highway host that clocks frames and trades samples
// Assumes: one transmit and one receive slot per frame
// Notes: pclk runs free, as a highway clock does between frames
module phw_host #(parameter int FRAME = 320) (
   output logic pclk,  // highway clock
   output logic frame_sync,  // frame start
   output logic pcm_din,  // serial data to device
   input wire logic pcm_dout,  // serial data from device
   input wire logic pcm_dout_oe,  // device drive
   input wire logic [9:0] tx_start,  // device transmit slot
   input wire logic [9:0] rx_start,  // device receive slot
   input wire logic [4:0] nbits,  // bits per slot
   input wire logic cpb,  // two pclks per bit
   input wire logic [15:0] send_word,  // word for receive slot
   output logic [15:0] cap_word,  // word caught last frame
   output int cap_n,  // bits caught last frame
   output logic tail_oe,  // drive seen after last bit
   output int frames  // completed frames
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   int k;
   int n = 0;
   logic [15:0] sh = 16'h0000;
   // clock with an odd start so its edges never meet an mclk edge
   initial begin
      pclk = 1'b0;
      frame_sync = 1'b0;
      pcm_din = 1'b0;
      frames = 0;
      #13;
      forever #40 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cnt = (cnt == FRAME - 1) ? 0 : cnt + 1;
      frame_sync <= (cnt == FRAME - 2);
      k = cnt - rx_start;
      if (k >= 0 && k < nbits * (cpb ? 2 : 1)) begin
         pcm_din <= send_word[nbits - 1 - k / (cpb ? 2 : 1)];
      end else begin
         pcm_din <= ~pcm_din;  // released line: no stale value
      end
      if (cnt == 0) begin
         cap_word <= sh;
         cap_n <= n;
         frames <= frames + 1;
         sh = 16'h0000;
         n = 0;
      end
   end
   // catch the device's bits on the last falling edge of each bit
   always @(negedge pclk) begin
      k = cnt - tx_start;
      if (k >= 0 && k < nbits * (cpb ? 2 : 1) && k % (cpb ? 2 : 1) == (cpb ? 1 : 0)) begin
         if (pcm_dout_oe === 1'b1) begin
            sh = {sh[14:0], pcm_dout};
            n = n + 1;
         end
      end
   end
   // drive state a quarter period into the first pclk after the slot, before its falling edge
   always @(posedge pclk) begin
      #20;
      if (cnt == tx_start + nbits * (cpb ? 2 : 1)) tail_oe = pcm_dout_oe;
   end
endmodule  // phw_host

// *** dv/pcm_highway_slot_config_bench.sv ***
// Purpose: self-checking bench of the highway slot block against a host model
// Assumes: companding follows the usual curves
// Notes: config changes only while transfers are off
module pcm_highway_slot_config_bench import phw_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic pclk, frame_sync, pcm_din, pcm_dout, pcm_dout_oe;
   logic [15:0] adc_sample = 16'h0000;
   logic adc_valid = 1'b0;
   logic [15:0] dac_sample;
   logic dac_valid;
   logic [9:0] h_tx = 10'h000;
   logic [9:0] h_rx = 10'h000;
   logic [4:0] h_nb = 5'h08;
   logic h_cpb = 1'b0;
   logic [15:0] h_word = 16'h0000;
   logic [15:0] cap_word;
   logic tail_oe;
   int cap_n, frames, errors = 0, check_count = 0, tick = 0;
   logic [15:0] adc_val = 16'h0000, last_dac = 16'h0000;
   int exp_q[$];
   int exp_v = 0;
   logic av_d = 1'b0, loop_on = 1'b0;
   logic [31:0] seed = 32'h0000_0062;
   logic [7:0] rv;

   always #20 mclk = ~mclk;

   phw_highway dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pclk(pclk),
      .frame_sync(frame_sync), .pcm_din(pcm_din), .pcm_dout(pcm_dout),
      .pcm_dout_oe(pcm_dout_oe), .adc_sample(adc_sample), .adc_valid(adc_valid),
      .dac_sample(dac_sample), .dac_valid(dac_valid));
   phw_host host (.pclk(pclk), .frame_sync(frame_sync), .pcm_din(pcm_din),
      .pcm_dout(pcm_dout), .pcm_dout_oe(pcm_dout_oe), .tx_start(h_tx), .rx_start(h_rx),
      .nbits(h_nb), .cpb(h_cpb), .send_word(h_word), .cap_word(cap_word), .cap_n(cap_n),
      .tail_oe(tail_oe), .frames(frames));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] mu_enc(input logic [15:0] x);
      int p, s;
      logic [7:0] m;
      p = $signed(x);
      m = (p < 0) ? 8'h7F : 8'hFF;
      p = ((p < 0) ? -p : p) >> 2;
      if (p > 8158) p = 8158;
      p = p + 33;
      s = 0;
      while (s < 7 && p > (64 << s) - 1) s++;
      return 8'((s << 4) | ((p >> (s + 1)) & 15)) ^ m;
   endfunction
   function automatic logic [7:0] a_enc(input logic [15:0] x);
      int p, s;
      logic [7:0] m;
      p = $signed(x) >>> 3;
      m = (p >= 0) ? 8'hD5 : 8'h55;
      if (p < 0) p = -p - 1;
      s = 0;
      while (s < 7 && p > (32 << s) - 1) s++;
      return 8'((s << 4) | ((p >> ((s < 2) ? 1 : s)) & 15)) ^ m;
   endfunction
   function automatic logic [15:0] mu_dec(input logic [7:0] c);
      int u, t;
      u = ~c & 255;
      t = (((u & 15) << 3) + 132) << ((u >> 4) & 7);
      return 16'((u & 128) ? 132 - t : t - 132);
   endfunction
   function automatic logic [15:0] a_dec(input logic [7:0] c);
      int a, t, s;
      a = c ^ 85;
      s = (a >> 4) & 7;
      t = (a & 15) << 4;
      if (s == 0) t += 8;
      else if (s == 1) t += 264;
      else t = (t + 264) << (s - 1);
      return 16'((a & 128) ? t : -t);
   endfunction

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge mclk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   task automatic wait_frames(input int n);
      int f;
      f = frames;
      wait (frames >= f + n);
   endtask
   // one format pass: counts set while off, then enabled, last full frame judged
   task automatic run_fmt(input logic [1:0] fmt, input logic c, input logic tr,
                          input logic [9:0] t, input logic [9:0] r);
      logic [15:0] ew, ed;
      wr(PHW_A_MODE, 8'h00);
      wr(PHW_A_TXLO, t[7:0]);
      wr(PHW_A_TXHI, {6'h00, t[9:8]});
      wr(PHW_A_RXLO, r[7:0]);
      wr(PHW_A_RXHI, {6'h00, r[9:8]});
      h_tx = t;
      h_rx = r;
      h_cpb = c;
      h_nb = (fmt == PHW_FMT_LIN16) ? PHW_BITS_WIDE : PHW_BITS_NARROW;
      h_word = rnd();
      if (fmt != PHW_FMT_LIN16) h_word[15:8] = 8'h00;
      adc_val = rnd();
      wr(PHW_A_MODE, {2'b00, 1'b1, fmt, 1'b0, c, tr});  // bit two kept zero
      wait_frames(3);
      case (fmt)
         PHW_FMT_ALAW: {ew, ed} = {8'h00, a_enc(adc_val), a_dec(h_word[7:0])};
         PHW_FMT_MULAW: {ew, ed} = {8'h00, mu_enc(adc_val), mu_dec(h_word[7:0])};
         PHW_FMT_LIN8: {ew, ed} = {8'h00, adc_val[15:8], h_word[7:0], 8'h00};
         default: {ew, ed} = {adc_val, h_word};
      endcase
      check("tx word", cap_word, ew);
      check("tx bits", 16'(cap_n), 16'(h_nb));
      check("release", {15'h0000, tail_oe}, {15'h0000, tr});
      check("rx word", last_dac, ed);
   endtask

   // line samples offered every 64 mclk
   always @(negedge mclk) begin
      tick = tick + 1;
      adc_valid <= (tick % 64 == 0);
      adc_sample <= adc_val;
   end
   // line side monitor; in loopback each sample returns the next cycle
   always @(posedge mclk) begin
      if (dac_valid === 1'b1) last_dac <= dac_sample;
      if (av_d) exp_v = exp_q.pop_front();
      if (loop_on && av_d) check("loop data", dac_sample, 16'(exp_v));
      if (loop_on) check("loop only", {15'h0000, dac_valid}, {15'h0000, av_d});
      if (adc_valid === 1'b1) exp_q.push_back(int'(adc_sample));
      av_d <= adc_valid;
   end

   initial begin
      #3ms;
      errors++;
      print_verdict();
   end

   initial begin
      repeat (2) @(negedge mclk);
      rst_b = 1'b1;
      rd(PHW_A_MODE, rv);
      check("mode reset", {8'h00, rv}, {8'h00, PHW_RST_MODE});
      for (int a = 8'h22; a <= 8'h25; a++) begin
         rd(8'(a), rv);
         check("slot reset", {8'h00, rv}, {8'h00, PHW_RST_SLOT});
      end
      wr(PHW_A_TXHI, 8'hFF);
      rd(PHW_A_TXHI, rv);
      check("tx high", {8'h00, rv}, 16'h0003);
      wr(PHW_A_RXHI, 8'hFF);
      rd(PHW_A_RXHI, rv);
      check("rx high", {8'h00, rv}, 16'h0003);
      wr(8'h30, 8'h5A);
      rd(8'h30, rv);
      check("unmapped", {8'h00, rv}, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         run_fmt(2'(i), i[2] ^ i[0], i[2] ^ i[1], (i == 7) ? 10'h105 : 10'(rnd() % 64),
                 (i == 6) ? 10'h0F0 : 10'(rnd() % 64));
      end
      // transfers off: no slot is driven
      wr(PHW_A_MODE, 8'h18);
      wait_frames(3);
      check("off bits", 16'(cap_n), 16'h0000);
      wr(PHW_A_MODE, 8'hE0);
      rd(PHW_A_MODE, rv);
      check("mode rw", {8'h00, rv}, 16'h00E0);
      repeat (4) @(negedge mclk);
      loop_on = 1'b1;
      adc_val = rnd();
      wait_frames(2);
      loop_on = 1'b0;
      check("loop last", last_dac, adc_val);
      print_verdict();
   end
endmodule  // pcm_highway_slot_config_bench
